//--- src/vcpat_table_load.sv
`timescale 1ns/1ps
// How it works
// - Writing one to load bit loads table
// - Writing zero to load bit: no action
// - Load bit always reads zero
// - Load bit ignored on downstream ports
// - Load acts only for table-based scheme
// - Three-bit scheme select, read/write, reset zero
// - Channel identifier reads zero
// - Channel enable reads one
// - Table write sets table status
// - Status clears when load finishes
// - Status reads zero on downstream ports
// - Status meaningful for table scheme; resets zero
// - Negotiation pending mirrors flow-control init
// - Capability: up 0x3, down 0x1
// - Arbiter skips invalid port phases
module vcpat_table_load
    import vcpat_pkg::*;
#(
    parameter bit IS_UPSTREAM = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Register port
    input wire logic [11:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // Link state
    input wire logic fcInitBusy,
    // Arbiter side
    output logic [PHASES*PHASE_W-1:0] arbTable,
    output logic [PHASES-1:0] arbPhaseValid,
    output logic [2:0] arbScheme,
    output logic arbLoadDone
);

    localparam logic [7:0] CAP = IS_UPSTREAM ? CAP_UP : CAP_DOWN;

    typedef struct packed {
        logic [31:0] rdata;
        logic [2:0] sel;
        logic tstat;
        logic fcSync1;
        logic fcSync2;
        logic neg;
        logic [TBL_WORDS-1:0][31:0] shadow;
        logic [PHASES*PHASE_W-1:0] active;
        logic [PHASES-1:0] valid;
        vcpat_state_t state;
        logic [1:0] word;
        logic [3:0] wait_;
        logic done;
    } vcpat_regs_t;

    vcpat_regs_t r_ff;
    vcpat_regs_t nxt_r;

    logic isTblAddr;
    logic [1:0] tblIdx;
    logic schemeUsesTable;
    logic loadReq;

    assign isTblAddr = regAddr >= TBL_BASE && regAddr <= TBL_LAST
        && regAddr[1:0] == 2'h0;
    assign tblIdx = regAddr[3:2];
    assign schemeUsesTable = r_ff.sel < 3'h7
        && CAP[r_ff.sel] && CAP_TABLE_MASK[r_ff.sel];
    assign loadReq = IS_UPSTREAM && regWrite && regAddr == CTL_OFFSET
        && regWdata[LOAD_BIT] && schemeUsesTable;

    // -------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------
    always_comb begin
        logic [31:0] w;
        w = 32'h0;
        nxt_r = r_ff;
        nxt_r.done = 1'b0;
        // Two-flop sync: link init status is from another domain
        nxt_r.fcSync1 = fcInitBusy;
        nxt_r.fcSync2 = r_ff.fcSync1;
        nxt_r.neg = r_ff.fcSync2;

        if (regWrite && regAddr == CTL_OFFSET) begin
            nxt_r.sel = regWdata[SEL_LSB +: SEL_W];
        end
        if (regWrite && isTblAddr && IS_UPSTREAM) begin
            nxt_r.shadow[tblIdx] = regWdata;
        end

        // Loader walks the shadow one word at a time
        case (r_ff.state)
            VCPAT_IDLE: begin
            end
            VCPAT_LOAD: begin
                if (r_ff.wait_ != 4'h0) begin
                    nxt_r.wait_ = r_ff.wait_ - 4'h1;
                end else begin
                    w = r_ff.shadow[r_ff.word];
                    nxt_r.active[r_ff.word*32 +: 32] = w;
                    for (int i = 0; i < 8; i++) begin
                        nxt_r.valid[r_ff.word*8 + i] =
                            w[i*PHASE_W +: PHASE_W] <= MAX_PORT;
                    end
                    nxt_r.wait_ = LOAD_WORD_CYCLES - 4'h1;
                    if (r_ff.word == 2'(TBL_WORDS - 1)) begin
                        nxt_r.state = VCPAT_DONE;
                    end else begin
                        nxt_r.word = r_ff.word + 2'h1;
                    end
                end
            end
            VCPAT_DONE: begin
                nxt_r.tstat = 1'b0;
                nxt_r.done = 1'b1;
                nxt_r.state = VCPAT_IDLE;
            end
            default: begin
                nxt_r.state = VCPAT_IDLE;
            end
        endcase

        if (loadReq) begin
            nxt_r.state = VCPAT_LOAD;
            nxt_r.word = 2'h0;
            nxt_r.wait_ = LOAD_WORD_CYCLES - 4'h1;
            nxt_r.done = 1'b0;
        end
        // Table write sets status, wins over clear
        if (regWrite && isTblAddr && IS_UPSTREAM) begin
            nxt_r.tstat = 1'b1;
        end

        nxt_r.rdata = 32'h0;
        if (regRead) begin
            if (regAddr == CTL_OFFSET) begin
                nxt_r.rdata[SEL_LSB +: SEL_W] = r_ff.sel;
                nxt_r.rdata[CHID_LSB +: 3] = CHID_VALUE;
                nxt_r.rdata[CHEN_BIT] = CHEN_VALUE;
            end else if (regAddr == STS_OFFSET) begin
                nxt_r.rdata[TSTAT_BIT] = IS_UPSTREAM && r_ff.tstat;
                nxt_r.rdata[NEG_BIT] = r_ff.neg;
            end else if (isTblAddr && IS_UPSTREAM) begin
                nxt_r.rdata = r_ff.shadow[tblIdx];
            end
        end
    end

    // -------------------------------------------------------------
    // State register
    // -------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            r_ff <= '0;
            r_ff.sel <= SEL_RESET;
            r_ff.state <= VCPAT_IDLE;
            r_ff.valid <= '1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign regRdata = r_ff.rdata;
    assign arbTable = r_ff.active;
    assign arbPhaseValid = r_ff.valid;
    assign arbScheme = r_ff.sel;
    assign arbLoadDone = r_ff.done;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    AST_LOAD_READS_ZERO: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        regRead && regAddr == CTL_OFFSET |=> !regRdata[LOAD_BIT])
        else $error("load bit read back nonzero");

    AST_ZERO_NO_LOAD: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        regWrite && regAddr == CTL_OFFSET && !regWdata[LOAD_BIT]
        && r_ff.state == VCPAT_IDLE |=> r_ff.state == VCPAT_IDLE)
        else $error("zero write started a load");

    AST_LOAD_STARTS: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        loadReq |=> r_ff.state == VCPAT_LOAD && r_ff.word == 2'h0)
        else $error("load did not start");

    // Four word steps and the done step, then the pulse
    AST_LOAD_FINISHES: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        loadReq ##1 !loadReq [*5] |=> arbLoadDone)
        else $error("load did not complete in time");

    AST_TBL_SETS_STATUS: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        IS_UPSTREAM && regWrite && isTblAddr |=> r_ff.tstat)
        else $error("table write did not set status");

    AST_DONE_CLEARS: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        arbLoadDone && !$past(regWrite && isTblAddr) |-> !r_ff.tstat)
        else $error("status still set after load");

    AST_CTL_FIXED: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        regRead && regAddr == CTL_OFFSET |=>
        regRdata[CHEN_BIT] && regRdata[CHID_LSB +: 3] == 3'h0)
        else $error("channel id or enable wrong");

    AST_DOWN_STATUS: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !IS_UPSTREAM && regRead && regAddr == STS_OFFSET
        |=> !regRdata[TSTAT_BIT])
        else $error("downstream status bit set");

    AST_NEG_FOLLOWS: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        fcInitBusy [*4] |-> r_ff.neg)
        else $error("negotiation pending not reflected");

    AST_SEL_WRITE: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        regWrite && regAddr == CTL_OFFSET |=>
        arbScheme == $past(regWdata[SEL_LSB +: SEL_W]))
        else $error("scheme select not stored");

    // -------------------------------------------------------------
    // Further checks
    // -------------------------------------------------------------
    // Reference validity, kept apart from the loader's own copy
    logic [PHASES-1:0] phaseOk;
    always_comb begin
        for (int p = 0; p < PHASES; p++) begin
            phaseOk[p] = r_ff.active[p*PHASE_W +: PHASE_W] <= MAX_PORT;
        end
    end

    AST_VALID_SKIP: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        arbPhaseValid == phaseOk)
        else $error("phase valid flags disagree with table");

    AST_DOWN_NO_LOAD: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !IS_UPSTREAM && regWrite && regAddr == CTL_OFFSET
        && regWdata[LOAD_BIT] |=> r_ff.state == VCPAT_IDLE)
        else $error("downstream port started a load");

    AST_DOWN_TABLE: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !IS_UPSTREAM && regRead && isTblAddr |=> regRdata == 32'h0)
        else $error("downstream table word not zero");

    // Only scheme one walks the table
    AST_NO_TABLE_NO_LOAD: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        regWrite && regAddr == CTL_OFFSET && arbScheme != 3'h1
        && r_ff.state == VCPAT_IDLE |=> r_ff.state == VCPAT_IDLE)
        else $error("load started without table scheme");

    AST_ZERO_NO_STATUS: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        regWrite && regAddr == CTL_OFFSET && !regWdata[LOAD_BIT]
        && r_ff.state == VCPAT_IDLE |=> $stable(r_ff.tstat))
        else $error("zero write changed table status");

    AST_STATUS_SOURCE: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !r_ff.tstat && !(regWrite && isTblAddr) |=> !r_ff.tstat)
        else $error("table status set without table write");

    AST_STATUS_HOLDS: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        r_ff.tstat && r_ff.state != VCPAT_DONE |=> r_ff.tstat)
        else $error("table status cleared before load end");

    AST_DONE_PULSE: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        arbLoadDone |=> !arbLoadDone)
        else $error("load done held longer than one cycle");

    AST_RESTART: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        loadReq && r_ff.state == VCPAT_LOAD
        |=> r_ff.state == VCPAT_LOAD && r_ff.word == 2'h0 && !arbLoadDone)
        else $error("load request did not restart load");

    AST_SEL_HOLDS: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !(regWrite && regAddr == CTL_OFFSET) |=> $stable(arbScheme))
        else $error("scheme select changed without a write");

    AST_SEL_READ: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        regRead && regAddr == CTL_OFFSET |=>
        regRdata[SEL_LSB +: SEL_W] == arbScheme)
        else $error("scheme select read back wrong");

    AST_CHID_ZERO: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        regRead && regAddr == CTL_OFFSET |=>
        regRdata[CHID_LSB +: 3] == CHID_VALUE)
        else $error("channel identifier not zero");

    AST_NEG_CLEARS: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !fcInitBusy [*4] |-> !r_ff.neg)
        else $error("negotiation pending stuck");

    AST_NEG_READ: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        regRead && regAddr == STS_OFFSET |=>
        regRdata[NEG_BIT] == $past(r_ff.neg))
        else $error("negotiation pending read back wrong");

    AST_STS_RESERVED: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        regRead && regAddr == STS_OFFSET |=>
        regRdata[15:0] == 16'h0 && regRdata[31:18] == 14'h0)
        else $error("status reserved bits not zero");

    AST_RDATA_QUIET: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !regRead |=> regRdata == 32'h0)
        else $error("read data outside read cycle");

endmodule

//--- inc/vcpat_pkg.sv
package vcpat_pkg;
    // -------------------------------------------------------------
    // Register map (byte addresses)
    // -------------------------------------------------------------
    localparam logic [11:0] CTL_OFFSET = 12'h214;
    localparam logic [11:0] STS_OFFSET = 12'h218;
    localparam logic [11:0] TBL_BASE = 12'h220;
    localparam logic [11:0] TBL_LAST = 12'h22C;
    localparam int TBL_WORDS = 4;
    localparam int PHASES = 32;
    localparam int PHASE_W = 4;

    // -------------------------------------------------------------
    // Control fields
    // -------------------------------------------------------------
    localparam int LOAD_BIT = 16;
    localparam int SEL_LSB = 17;
    localparam int SEL_W = 3;
    localparam int CHID_LSB = 24;
    localparam int CHEN_BIT = 31;
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [2:0] CHID_VALUE = 3'h0;
    localparam logic CHEN_VALUE = 1'h1;

    // -------------------------------------------------------------
    // Status fields
    // -------------------------------------------------------------
    localparam int TSTAT_BIT = 16;
    localparam int NEG_BIT = 17;

    // -------------------------------------------------------------
    // Capability and arbitration
    // -------------------------------------------------------------
    localparam logic [7:0] CAP_UP = 8'h03;
    localparam logic [7:0] CAP_DOWN = 8'h01;
    localparam logic [7:0] CAP_TABLE_MASK = 8'h02;
    localparam logic [3:0] MAX_PORT = 4'h6;
    localparam int NUM_PORTS = 7;

    // Cycles the arbiter needs to latch one table word
    localparam logic [3:0] LOAD_WORD_CYCLES = 4'h1;

    typedef enum logic [2:0] {
        VCPAT_IDLE = 3'b001,
        VCPAT_LOAD = 3'b010,
        VCPAT_DONE = 3'b100
    } vcpat_state_t;
endpackage

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import vcpat_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] regAddr = 12'h000;
    logic [31:0] regWdata = 32'h00000000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic fcInitBusy = 1'b0;
    logic [31:0] regRdata, dnRdata, rd, rdd, y;
    logic [PHASES*PHASE_W-1:0] arbTable, tbl;
    logic [PHASES-1:0] arbPhaseValid;
    logic [2:0] arbScheme;
    logic arbLoadDone, dnDone, sel0;
    logic [31:0] seed = 32'h00000049;
    int fails = 0, n_checks = 0, nDone = 0, nDnDone = 0, cyc = 0, n0;

    vcpat_table_load #(.IS_UPSTREAM(1'b1)) u_vcpat_table_load (
        .ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .fcInitBusy(fcInitBusy), .arbTable(arbTable),
        .arbPhaseValid(arbPhaseValid), .arbScheme(arbScheme),
        .arbLoadDone(arbLoadDone));
    // Downstream twin sees select 0, its only scheme
    vcpat_table_load #(.IS_UPSTREAM(1'b0)) u_vcpat_table_load_dn (
        .ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWdata(regWdata & 32'hFFF1FFFF), .regWrite(regWrite),
        .regRead(regRead),
        .regRdata(dnRdata), .fcInitBusy(fcInitBusy), .arbTable(),
        .arbPhaseValid(), .arbScheme(), .arbLoadDone(dnDone));

    initial forever #2.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cyc++;
        if (arbLoadDone === 1'b1) nDone++;
        if (dnDone === 1'b1) nDnDone++;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] expCtl(input logic s);
        return {CHEN_VALUE, 4'h0, CHID_VALUE, 4'h0, 2'b00, s, 17'h00000};
    endfunction

    function automatic logic [31:0] expValid(input logic [127:0] t);
        logic [31:0] v;
        for (int i = 0; i < PHASES; i++) begin
            v[i] = (t[i*PHASE_W +: PHASE_W] <= MAX_PORT);
        end
        return v;
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rdb(input logic [11:0] a);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 rd = regRdata;
        rdd = dnRdata;
    endtask

    // Random filler in reserved and read-only bits
    task automatic wctl(input logic s, input logic ld);
        seed = lfsr(seed);
        wr(CTL_OFFSET, {seed[31:20], 2'b00, s, ld, seed[15:0]});
    endtask

    task automatic rndTable();
        for (int w = 0; w < TBL_WORDS; w++) begin
            seed = lfsr(seed);
            tbl[w*32 +: 32] = seed;
            wr(TBL_BASE + 12'(w * 4), seed);
        end
    endtask

    task automatic waitLoad(input int base);
        for (int i = 0; i < 30 && nDone == base; i++) @(posedge ref_clk);
        #1;
    endtask

    task automatic finish_test();
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        rdb(CTL_OFFSET);
        chk("ctl", rd, expCtl(1'b0));
        chk("dnCtl", rdd, expCtl(1'b0));
        rdb(STS_OFFSET);
        chk("sts", rd, 32'h00000000);
        for (int i = 0; i < 6; i++) begin
            sel0 = seed[3];
            // Upstream schemes 0 and 1 only
            wctl(sel0, 1'b0);
            rdb(CTL_OFFSET);
            chk("ctl", rd, expCtl(sel0));
            chk("scheme", {29'h0, arbScheme}, {31'h0, sel0});
        end
        wr(12'h230, seed);
        rdb(STS_OFFSET);
        chk("stsUnmapped", rd, 32'h00000000);
        rdb(12'h230);
        chk("unmapped", rd, 32'h00000000);
        for (int k = 0; k < 3; k++) begin
            wctl(1'b1, 1'b0);
            rndTable();
            rdb(STS_OFFSET);
            chk("stsSet", rd, 32'h00010000);
            chk("dnSts", rdd, 32'h00000000);
            rdb(TBL_BASE);
            chk("tblRead", rd, tbl[31:0]);
            chk("dnTbl", rdd, 32'h00000000);
            wctl(1'b1, 1'b0);
            repeat (8) @(posedge ref_clk);
            rdb(STS_OFFSET);
            chk("stsKept", rd, 32'h00010000);
            n0 = nDone;
            wctl(1'b1, 1'b1);
            waitLoad(n0);
            chk("doneCount", nDone - n0, 32'h00000001);
            for (int w = 0; w < TBL_WORDS; w++) begin
                chk("table", arbTable[w*32 +: 32], tbl[w*32 +: 32]);
            end
            chk("valid", arbPhaseValid, expValid(tbl));
            rdb(STS_OFFSET);
            chk("stsClr", rd, 32'h00000000);
            rdb(CTL_OFFSET);
            chk("ctlLoad", rd, expCtl(1'b1));
        end
        rndTable();
        n0 = nDone;
        // Load bit is judged against the select already stored
        wctl(1'b0, 1'b0);
        wctl(1'b0, 1'b1);
        repeat (12) @(posedge ref_clk);
        chk("noLoad", nDone - n0, 32'h00000000);
        rdb(STS_OFFSET);
        chk("stsNoLoad", rd, 32'h00010000);
        wctl(1'b1, 1'b0);
        n0 = nDone;
        wctl(1'b1, 1'b1);
        seed = lfsr(seed);
        y = seed;
        wr(TBL_BASE, y);
        wctl(1'b1, 1'b1);
        waitLoad(n0);
        repeat (10) @(posedge ref_clk);
        chk("restart", arbTable[31:0], y);
        chk("restartDone", nDone - n0, 32'h00000001);
        rdb(STS_OFFSET);
        chk("stsRestart", rd, 32'h00000000);
        @(posedge ref_clk);
        fcInitBusy <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rdb(STS_OFFSET);
        chk("negSet", rd, 32'h00020000);
        @(posedge ref_clk);
        fcInitBusy <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rdb(STS_OFFSET);
        chk("negClr", rd, 32'h00000000);
        chk("dnDone", nDnDone, 32'h00000000);
        finish_test();
    end
endmodule
